//--- common/adc_seq_pkg.sv
package adc_seq_pkg;

    // ****************************************************************
    // register map and bus
    // ****************************************************************
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned BUF_DEPTH = 16;
    localparam logic [5:0] CTRL_ONE_ADDR = 6'h00;
    localparam logic [5:0] CTRL_TWO_ADDR = 6'h01;
    localparam logic [5:0] CTRL_THREE_ADDR = 6'h02;
    localparam logic [1:0] BUF_PAGE = 2'h1;
    localparam logic [3:0] HALF_BASE = 4'h8;
    localparam logic [3:0] BUF_START = 4'h0;

    localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
    localparam logic [15:0] CTRL_TWO_RESET = 16'h0000;
    localparam logic [15:0] CTRL_THREE_RESET = 16'h0000;
    localparam logic [15:0] CTRL_ONE_WMASK = 16'hA7EC;
    localparam logic [15:0] CTRL_TWO_WMASK = 16'hE73F;
    localparam logic [15:0] CTRL_THREE_WMASK = 16'h1F3F;

    // ****************************************************************
    // field positions and codes
    // ****************************************************************
    localparam int unsigned SAMPLE_BIT = 1;
    localparam int unsigned DONE_BIT = 0;
    localparam int unsigned SIMULTANEOUS_SAMPLE_BIT = 3;
    localparam int unsigned FILL_BIT = 7;
    localparam logic [2:0] TRIG_SOFT = 3'h0;
    localparam logic [2:0] TRIG_PIN = 3'h1;
    localparam logic [2:0] TRIG_TIMER = 3'h2;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    localparam logic [1:0] FMT_SIGNED = 2'h1;

    // ****************************************************************
    // timing in conversion clock periods
    // ****************************************************************
    localparam logic [4:0] CONV_TAD_TEN = 5'h0C;
    localparam logic [4:0] CONV_TAD_TWELVE = 5'h0E;
    localparam logic [4:0] TAD_SATURATE = 5'h1F;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic on;
        logic rsv14;
        logic stop_idle;
        logic [1:0] rsv12;
        logic res_mode;
        logic [1:0] out_format;
        logic [2:0] trig_src;
        logic rsv4;
        logic simultaneous_sample;
        logic auto_start;
        logic sample;
        logic done;
    } ctrl_one_t;

    typedef struct packed {
        logic [2:0] ref_cfg;
        logic [1:0] rsv12;
        logic scan_en;
        logic [1:0] chan_count;
        logic fill_status;
        logic rsv6;
        logic [3:0] irq_rate;
        logic buf_mode;
        logic alt_sample;
    } ctrl_two_t;

    typedef struct packed {
        logic [2:0] rsv15;
        logic [4:0] sample_time;
        logic [1:0] rsv7;
        logic [5:0] clk_sel;
    } ctrl_three_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11,
        ST_RESAMPLE = 2'b10
    } seq_state_t;

endpackage

//--- src/result_buffer.sv
`timescale 1ns/1ps
module result_buffer
    import adc_seq_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic wr_en_in,
    input wire logic [3:0] wr_addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic rd_mem_in,
    input wire logic [3:0] rd_addr_in,
    input wire logic [15:0] rd_alt_in,
    output logic [15:0] rd_data_out
);
    logic [15:0] mem_q [BUF_DEPTH];
    logic [15:0] rd_data_q;

    always_ff @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    // read register also carries the control register words
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            rd_data_q <= '0;
        end else if (rd_mem_in) begin
            rd_data_q <= mem_q[rd_addr_in];
        end else begin
            rd_data_q <= rd_alt_in;
        end
    end

    assign rd_data_out = rd_data_q;
endmodule

//--- src/adc_sequence_control.sv
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module adc_sequence_control
    import adc_seq_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [15:0] reg_rdata_out,
    input wire logic idle_mode_in,
    input wire logic timer3_match_in,
    input wire logic external_interrupt_pin_in,
    input wire logic [11:0] conv_data_in,
    output logic sample_hold_out,
    output logic conv_start_out,
    output logic [1:0] channel_out,
    output logic alt_select_b_out,
    output logic converter_irq_flag_out,
    output logic resolution_mode_out,
    output logic [2:0] reference_config_out,
    output logic scan_enable_out
);
    // ****************************************************************
    // registers and bus decode
    // ****************************************************************
    reg_req_t req;
    ctrl_one_t ctrl1_q;
    ctrl_two_t ctrl2_q;
    ctrl_three_t ctrl3_q;
    ctrl_one_t rd_one;
    ctrl_two_t rd_two;
    logic [15:0] rd_alt;
    logic ctrl1_wr;
    logic rd_mem;

    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_write_in, rd: reg_read_in};
    assign ctrl1_wr = req.wr && (req.addr == CTRL_ONE_ADDR);
    assign rd_mem = req.rd && (req.addr[5:4] == BUF_PAGE);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            ctrl1_q <= ctrl_one_t'(CTRL_ONE_RESET);
        end else if (ctrl1_wr) begin
            ctrl1_q <= ctrl_one_t'(req.wdata & CTRL_ONE_WMASK);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            ctrl2_q <= ctrl_two_t'(CTRL_TWO_RESET);
            ctrl3_q <= ctrl_three_t'(CTRL_THREE_RESET);
        end else if (req.wr && req.addr == CTRL_TWO_ADDR) begin
            ctrl2_q <= ctrl_two_t'(req.wdata & CTRL_TWO_WMASK);
        end else if (req.wr && req.addr == CTRL_THREE_ADDR) begin
            ctrl3_q <= ctrl_three_t'(req.wdata & CTRL_THREE_WMASK);
        end
    end

    // ****************************************************************
    // effective configuration
    // ****************************************************************
    logic run;
    logic res12;
    logic simultaneous_sample_eff;
    logic [1:0] chps_eff;
    logic [1:0] last_chan;
    logic [4:0] conv_len;

    function automatic logic [1:0] last_channel(input logic [1:0] chps);
        logic [1:0] last;
        last = 2'h0;
        if (chps[1]) begin
            last = 2'h3;
        end else if (chps[0]) begin
            last = 2'h1;
        end
        return last;
    endfunction

    function automatic logic [15:0] format_result(input logic [11:0] raw, input logic mode12, input logic [1:0] fmt);
        logic [15:0] word;
        word = {6'h00, raw[9:0]};
        if (mode12) begin
            word = {4'h0, raw};
            if (fmt == FMT_SIGNED) begin
                word = {{5{~raw[11]}}, raw[10:0]};
            end
        end else if (fmt == FMT_SIGNED) begin
            word = {{7{~raw[9]}}, raw[8:0]};
        end
        return word;
    endfunction

    assign run = ctrl1_q.on && !(ctrl1_q.stop_idle && idle_mode_in);
    assign res12 = ctrl1_q.res_mode;
    assign simultaneous_sample_eff = ctrl1_q.simultaneous_sample && !res12;
    assign chps_eff = res12 ? 2'h0 : ctrl2_q.chan_count;
    assign last_chan = last_channel(chps_eff);
    assign conv_len = res12 ? CONV_TAD_TWELVE : CONV_TAD_TEN;

    // ****************************************************************
    // external pin synchroniser and edge
    // ****************************************************************
    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_prev_q;
    logic pin_edge;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= external_interrupt_pin_in;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end
    assign pin_edge = pin_sync_q && !pin_prev_q;

    // ****************************************************************
    // conversion clock and phase counter
    // ****************************************************************
    seq_state_t state_q;
    seq_state_t state_d;
    logic [5:0] presc_q;
    logic [4:0] tad_cnt_q;
    logic tad_tick;
    logic trig_fire;
    logic sample_end;
    logic conv_end;
    logic seq_end;

    assign tad_tick = (presc_q == ctrl3_q.clk_sel);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !run || state_q == ST_IDLE || tad_tick) begin
            presc_q <= 6'h00;
        end else begin
            presc_q <= presc_q + 6'h01;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || state_d != state_q || conv_end) begin
            tad_cnt_q <= 5'h00;
        end else if (tad_tick && tad_cnt_q != TAD_SATURATE) begin
            tad_cnt_q <= tad_cnt_q + 5'h01;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        case (ctrl1_q.trig_src)
            TRIG_SOFT: trig_fire = ctrl1_wr && !req.wdata[SAMPLE_BIT];
            TRIG_PIN: trig_fire = pin_edge;
            TRIG_TIMER: trig_fire = timer3_match_in;
            TRIG_AUTO: trig_fire = (tad_cnt_q == ctrl3_q.sample_time);
            default: trig_fire = 1'b0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        sample_end = 1'b0;
        conv_end = 1'b0;
        seq_end = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (ctrl1_q.auto_start || (ctrl1_wr && req.wdata[SAMPLE_BIT])) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (trig_fire) begin
                    state_d = ST_CONVERT;
                    sample_end = 1'b1;
                end
            end
            ST_CONVERT: begin
                if (tad_tick && tad_cnt_q == conv_len - 5'h01) begin
                    conv_end = 1'b1;
                    if (channel_out == last_chan) begin
                        seq_end = 1'b1;
                        state_d = ctrl1_q.auto_start ? ST_SAMPLE : ST_IDLE;
                    end else begin
                        state_d = simultaneous_sample_eff ? ST_CONVERT : ST_RESAMPLE;
                    end
                end
            end
            ST_RESAMPLE: begin
                if (tad_tick) begin
                    state_d = ST_CONVERT;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (!run) begin
            state_d = ST_IDLE;
            sample_end = 1'b0;
            conv_end = 1'b0;
            seq_end = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            state_q <= ST_IDLE;
            sample_hold_out <= 1'b0;
            conv_start_out <= 1'b0;
        end else begin
            state_q <= state_d;
            sample_hold_out <= (state_d == ST_SAMPLE) || (state_d == ST_RESAMPLE);
            conv_start_out <= (state_d == ST_CONVERT) && (state_q != ST_CONVERT || conv_end);
        end
    end

    // ****************************************************************
    // done flag
    // ****************************************************************
    logic done_q;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            done_q <= 1'b0;
        end else if (seq_end) begin
            done_q <= 1'b1;
        end else if (sample_end) begin
            done_q <= 1'b0;
        end else if (ctrl1_wr && !req.wdata[DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // ****************************************************************
    // channel, buffer pointer, interrupt rate, halves
    // ****************************************************************
    logic [3:0] wr_ptr_q;
    logic [3:0] seq_cnt_q;
    logic irq_fire;
    logic rd_two_fill_q;

    assign irq_fire = seq_end && (seq_cnt_q == ctrl2_q.irq_rate);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || state_q == ST_IDLE || seq_end) begin
            channel_out <= 2'h0;
        end else if (conv_end) begin
            channel_out <= channel_out + 2'h1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !ctrl1_q.on) begin
            seq_cnt_q <= 4'h0;
            converter_irq_flag_out <= 1'b0;
        end else begin
            converter_irq_flag_out <= irq_fire;
            if (irq_fire) begin
                seq_cnt_q <= 4'h0;
            end else if (seq_end) begin
                seq_cnt_q <= seq_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !ctrl1_q.on || !ctrl2_q.buf_mode) begin
            rd_two_fill_q <= 1'b0;
        end else if (irq_fire) begin
            rd_two_fill_q <= !rd_two_fill_q;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !ctrl1_q.on) begin
            wr_ptr_q <= BUF_START;
        end else if (irq_fire) begin
            wr_ptr_q <= (ctrl2_q.buf_mode && !rd_two_fill_q) ? HALF_BASE : BUF_START;
        end else if (conv_end) begin
            wr_ptr_q <= wr_ptr_q + 4'h1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !ctrl2_q.alt_sample) begin
            alt_select_b_out <= 1'b0;
        end else if (seq_end) begin
            alt_select_b_out <= !alt_select_b_out;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            resolution_mode_out <= 1'b0;
            reference_config_out <= 3'h0;
            scan_enable_out <= 1'b0;
        end else begin
            resolution_mode_out <= res12;
            reference_config_out <= ctrl2_q.ref_cfg;
            scan_enable_out <= ctrl2_q.scan_en;
        end
    end

    // ****************************************************************
    // readback and result buffer
    // ****************************************************************
    always_comb begin
        rd_one = ctrl1_q;
        rd_one.simultaneous_sample = simultaneous_sample_eff;
        rd_one.sample = sample_hold_out;
        rd_one.done = done_q;
        rd_two = ctrl2_q;
        rd_two.chan_count = chps_eff;
        rd_two.fill_status = rd_two_fill_q;
        rd_alt = 16'h0000;
        if (req.rd) begin
            case (req.addr)
                CTRL_ONE_ADDR: rd_alt = rd_one;
                CTRL_TWO_ADDR: rd_alt = rd_two;
                CTRL_THREE_ADDR: rd_alt = ctrl3_q;
                default: rd_alt = 16'h0000;
            endcase
        end
    end

    result_buffer u_buf (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .wr_en_in(conv_end),
        .wr_addr_in(wr_ptr_q),
        .wr_data_in(format_result(conv_data_in, res12, ctrl1_q.out_format)),
        .rd_mem_in(rd_mem),
        .rd_addr_in(req.addr[3:0]),
        .rd_alt_in(rd_alt),
        .rd_data_out(reg_rdata_out)
    );

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    off_idle_a: assert property (!ctrl1_q.on |=> state_q == ST_IDLE && !sample_hold_out)
        else $error("converter off but sequencer not idle");
    idle_halt_a: assert property (ctrl1_q.stop_idle && idle_mode_in |=> state_q == ST_IDLE)
        else $error("idle stop ignored");
    done_set_a: assert property (seq_end |=> done_q && !conv_end)
        else $error("done not set at end of sequence");
    done_clear_a: assert property (sample_end |=> !done_q && conv_start_out)
        else $error("done not cleared at conversion start");
    sw_clear_a: assert property (ctrl1_wr && req.wdata[15] && state_q == ST_CONVERT && !conv_end
        && run && !req.wdata[DONE_BIT] |=> state_q == ST_CONVERT && !done_q)
        else $error("clearing done disturbed conversion");
    soft_trig_a: assert property (state_q == ST_SAMPLE && run && ctrl1_q.trig_src == TRIG_SOFT
        && ctrl1_wr && !req.wdata[SAMPLE_BIT] |=> state_q == ST_CONVERT ##1 !sample_hold_out)
        else $error("software trigger did not start conversion");
    auto_start_a: assert property (seq_end && ctrl1_q.auto_start |=> sample_hold_out)
        else $error("auto-start did not resume sampling");
    simultaneous_sample_read_a: assert property (req.rd && req.addr == CTRL_ONE_ADDR && res12
        |=> !reg_rdata_out[SIMULTANEOUS_SAMPLE_BIT])
        else $error("simultaneous bit visible in 12-bit mode");
    format_sign_a: assert property (conv_end && !res12 && ctrl1_q.out_format == FMT_SIGNED
        |=> u_buf.mem_q[$past(wr_ptr_q)] == {{7{~$past(conv_data_in[9])}}, $past(conv_data_in[8:0])})
        else $error("signed 10-bit format wrong");
    irq_rate_a: assert property (converter_irq_flag_out |-> $past(seq_cnt_q) == $past(ctrl2_q.irq_rate))
        else $error("interrupt at wrong sequence count");
    tad_gap_a: assert property (state_q == ST_CONVERT && state_d != ST_IDLE && tad_tick
        && ctrl3_q.clk_sel == 6'h01 |=> !tad_tick ##1 tad_tick)
        else $error("conversion clock period wrong");

    seq_cover_c: cover property (seq_end && simultaneous_sample_eff && last_chan == 2'h3);
    auto_cover_c: cover property (sample_end && ctrl1_q.trig_src == TRIG_AUTO);
    half_cover_c: cover property (irq_fire && ctrl2_q.buf_mode && rd_two_fill_q);
endmodule

//--- tb/sar_core_model.sv
`timescale 1ns/1ps
module sar_core_model (
    input wire logic clk_sys_in,
    input wire logic sample_hold_in,
    input wire logic conv_start_in,
    input wire logic [11:0] level_in,
    output logic [11:0] conv_data_out
);
    logic held_q = 1'b0;
    // result holds from conversion start until the next sample, else it reads the inverted level
    always @(posedge clk_sys_in) begin
        if (conv_start_in)
            held_q <= 1'b1;
        else if (sample_hold_in)
            held_q <= 1'b0;
    end
    assign conv_data_out = held_q ? level_in : ~level_in;
endmodule

//--- tb/adc_sequence_control_tb.sv
`timescale 1ns/1ps
module adc_sequence_control_tb;
    import adc_seq_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, idle = 1'b0, tmr = 1'b0, pin = 1'b0;
    logic sh, cs, irq, res_o, alt, scan_o;
    logic [1:0] ch;
    logic [2:0] ref_o;
    logic [5:0] addr = 6'h00;
    logic [15:0] wdata = 16'h0000, rdata, rv, w1, c1, ex;
    logic [11:0] level = 12'h000, cdata;
    logic [2:0] trigs [3] = '{TRIG_AUTO, TRIG_TIMER, TRIG_PIN};
    int miscompares = 0, n_tests = 0, cycles = 0, seed = 32'h52058870, c;
    adc_sequence_control uut (.clk_sys_in(clk), .resetn_in(resetn), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
        .idle_mode_in(idle), .timer3_match_in(tmr), .external_interrupt_pin_in(pin),
        .conv_data_in(cdata), .sample_hold_out(sh), .conv_start_out(cs), .channel_out(ch),
        .alt_select_b_out(alt), .converter_irq_flag_out(irq), .resolution_mode_out(res_o),
        .reference_config_out(ref_o), .scan_enable_out(scan_o));
    sar_core_model core (.clk_sys_in(clk), .sample_hold_in(sh), .conv_start_in(cs),
        .level_in(level), .conv_data_out(cdata));
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
    // ****************************************
    // bus, timing and checking helpers
    // ****************************************
    task automatic test_done();
        $display("compares %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s: %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_irq();
        c = 0;
        while (irq !== 1'b1 && c < 300) begin
            @(posedge clk);
            #1 c++;
        end
    endtask
    task automatic fire(input logic [2:0] t);
        @(posedge clk);
        tmr <= (t == TRIG_TIMER);
        pin <= (t == TRIG_PIN);
        @(posedge clk);
        tmr <= 1'b0;
        pin <= 1'b0;
    endtask
    function automatic logic [15:0] fmt(input logic [11:0] d, input logic r12, input logic [1:0] f);
        if (f != FMT_SIGNED)
            return r12 ? {4'h0, d} : {6'h00, d[9:0]};
        return r12 ? {{5{~d[11]}}, d[10:0]} : {{7{~d[9]}}, d[8:0]};
    endfunction
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            bus_rd(a == 3 ? 6'h3F : 6'(a), rv);
            cmp(rv, 16'h0000, "reset");
        end
        for (int n = 0; n < 4; n++) begin
            w1 = (16'($random(seed)) & 16'h7BFC) | {5'h00, n[0], 10'h000};
            c1 = 16'($random(seed));
            bus_wr(CTRL_ONE_ADDR, w1);
            bus_wr(CTRL_TWO_ADDR, c1);
            bus_rd(CTRL_ONE_ADDR, rv);
            cmp(rv, w1 & CTRL_ONE_WMASK & (n[0] ? 16'hFFF7 : 16'hFFFF), "ctl1");
            bus_rd(CTRL_TWO_ADDR, rv);
            cmp(rv, c1 & CTRL_TWO_WMASK & (n[0] ? 16'hFCFF : 16'hFFFF), "ctl2");
            cmp(16'(res_o), 16'(n[0]), "res");
            cmp(16'({ref_o, scan_o}), 16'({c1[15:13], c1[10]}), "ref scan");
        end
        $display("register test ended");
        for (int k = 0; k < 6; k++) begin
            level <= 12'($random(seed));
            c1 = {1'b1, 4'h0, k[0], 2'(k / 2), 8'h00};
            bus_wr(CTRL_THREE_ADDR, 16'(k));
            bus_wr(CTRL_TWO_ADDR, 16'h0000);
            bus_wr(CTRL_ONE_ADDR, c1 & 16'h7FFF);
            bus_wr(CTRL_ONE_ADDR, c1);
            bus_wr(CTRL_ONE_ADDR, c1 | 16'h0002);
            bus_rd(CTRL_ONE_ADDR, rv);
            cmp(rv | 16'(sh), c1 | 16'h0003, "sampling");
            bus_wr(CTRL_ONE_ADDR, c1);
            wait_irq();
            ex = 16'((k[0] ? CONV_TAD_TWELVE : CONV_TAD_TEN) * (k + 1));
            cmp(16'(c + k >= ex && c <= ex + 4), 16'h0001, "tconv");
            bus_rd({BUF_PAGE, BUF_START}, rv);
            cmp(rv, fmt(level, k[0], 2'(k / 2)), "word");
            bus_rd(CTRL_ONE_ADDR, rv);
            cmp(rv, c1 | 16'h0001, "done");
            bus_wr(CTRL_ONE_ADDR, c1);
            bus_rd(CTRL_ONE_ADDR, rv);
            cmp(rv, c1, "done clr");
            bus_wr(CTRL_ONE_ADDR, 16'h0000);
            $display("conversion test %0d ended", k);
        end
        for (int t = 0; t < 3; t++) begin
            level <= 12'($random(seed));
            c1 = {1'b0, 4'h0, 1'b1, FMT_SIGNED, trigs[t], 5'h04};
            bus_wr(CTRL_THREE_ADDR, 16'h0200);
            bus_wr(CTRL_ONE_ADDR, c1);
            bus_wr(CTRL_ONE_ADDR, c1 | 16'h8000);
            run(3);
            cmp(16'(sh), 16'h0001, "autostart");
            fire(trigs[t]);
            wait_irq();
            cmp(16'(c < 60), 16'h0001, "trigger");
            run(2);
            cmp(16'(sh), 16'h0001, "restart");
            ex = fmt(level, 1'b1, FMT_SIGNED);
            bus_rd({BUF_PAGE, BUF_START}, rv);
            cmp(rv, ex, "signed");
            level <= ~level;
            fire(trigs[t]);
            run(3);
            bus_rd(CTRL_ONE_ADDR, rv);
            cmp(16'(rv[DONE_BIT]), 16'h0000, "done start");
            bus_wr(CTRL_ONE_ADDR, c1 | 16'h8000);
            bus_wr(CTRL_ONE_ADDR, 16'h0000);
            run(40);
            bus_rd({BUF_PAGE, BUF_START}, rv);
            cmp(rv | 16'(sh), ex, "abort");
            $display("trigger test %0d ended", t);
        end
        for (int j = 0; j < 2; j++) begin
            bus_wr(CTRL_ONE_ADDR, {2'h2, j[0], 13'h0000});
            bus_wr(CTRL_ONE_ADDR, {2'h2, j[0], 13'h0002});
            idle <= 1'b1;
            run(4);
            cmp(16'(sh), 16'(!j[0]), "idle");
            idle <= 1'b0;
            bus_wr(CTRL_ONE_ADDR, 16'h0000);
        end
        $display("idle test ended");
        level <= 12'($random(seed));
        bus_wr(CTRL_THREE_ADDR, 16'h0000);
        bus_wr(CTRL_TWO_ADDR, 16'h0307);
        bus_wr(CTRL_ONE_ADDR, 16'h80EC);
        wait_irq();
        cmp(16'(c >= 8 * CONV_TAD_TEN && c < 8 * CONV_TAD_TEN + 8), 16'h0001, "rate");
        run(65);
        cmp(16'(ch), 16'h0001, "channel");
        cmp(16'(alt), 16'h0001, "alternate");
        for (int w = 7; w < 9; w++) begin
            bus_rd({BUF_PAGE, 4'(w)}, rv);
            cmp(rv, fmt(level, 1'b0, 2'h0), "words");
        end
        bus_rd(CTRL_TWO_ADDR, rv);
        cmp(rv, 16'h0387, "fill");
        $display("sequence test ended");
        test_done();
    end
endmodule
